// >>> pkg/wake_cfg.svh
// register map, field positions, reset values and timing counts of the wake-up core
`ifndef WAKE_CFG_SVH
`define WAKE_CFG_SVH

// ====================================================================
// register offsets
`define REG_STATUS_ONE 8'h03
`define REG_STATUS_GEN 8'h04
`define REG_RELEASE 8'h05
`define REG_ACCEL_BASE 8'h0A
`define REG_MAGNET_BASE 8'h10
`define REG_ROUTING 8'h2A
`define REG_PIN_CFG 8'h2C
`define REG_ACCEL_MASK 8'h2D
`define REG_MAGNET_MASK 8'h2E
`define REG_ACCEL_THRESH 8'h2F
`define REG_ACCEL_DUR 8'h30
`define REG_ACCEL_CTL 8'h31
`define REG_MAGNET_THRESH 8'h32
`define REG_MAGNET_DUR 8'h33
`define REG_MAGNET_CTL 8'h34
`define REG_RATE 8'h38
`define REG_ENABLE 8'h3A

// ====================================================================
// field positions
`define EN_ACCEL 0
`define EN_MAGNET 1
`define STAT_MAGNET_WAKE 0
`define STAT_ACCEL_WAKE 1
`define STAT_MAGNET_DRDY 3
`define STAT_ACCEL_DRDY 4
`define GEN_INT_PENDING 4
`define PIN_OPEN_DRAIN 1
`define PIN_ACTIVE_HIGH 2
`define PIN_PULSE 3
`define PIN_DISABLE 5
`define ENG_ENABLE 7
`define ENG_UNLATCHED 6

// ====================================================================
// reset values
`define RATE_RESET 8'h22
`define CFG_RESET 8'h00

// ====================================================================
// timing
`define CLK_PERIOD_NS 10
`define ODR_SLOW_PERIOD_US 80000
`define ENG_SLOW_PERIOD_US 1280000
`define INT_PULSE_TIME_US 50
`define US_TO_CYCLES(t) ((t) * 1000 / `CLK_PERIOD_NS)

`endif

// >>> pkg/wake_pkg.sv
// types shared by the wake-up core modules
package wake_pkg;

	typedef logic [2:0][15:0] axes_t;

	typedef enum logic [1:0] {ENG_IDLE, ENG_COUNT, ENG_FIRED} eng_mode_t;

	typedef struct packed {
		eng_mode_t mode;
		logic [7:0] count;
		axes_t prev;
		logic event_out;
	} engine_state_t;

	typedef struct packed {
		logic [31:0] count;
		logic tick;
	} tick_state_t;

	typedef struct packed {
		logic [7:0] routing;
		logic [7:0] pin_cfg;
		logic [7:0] amask;
		logic [7:0] mmask;
		logic [7:0] ath;
		logic [7:0] adur;
		logic [7:0] actl;
		logic [7:0] mth;
		logic [7:0] mdur;
		logic [7:0] mctl;
		logic [7:0] rate;
		logic [7:0] enable;
		axes_t accel;
		axes_t magnet;
		logic [4:0] status;
		logic pending;
		logic [15:0] pulse_cnt;
		logic [7:0] rd_data;
		logic rd_valid;
	} top_state_t;

endpackage : wake_pkg

// >>> pkg/engine_if.sv
// link between the core and one motion engine
`timescale 1ns/10ps
`default_nettype none

interface engine_if;
	logic tick;
	logic enable;
	logic differential;
	logic unlatched;
	logic [7:0] threshold;
	logic [7:0] duration;
	logic [5:0] mask;
	wake_pkg::axes_t sample;
	logic event_pulse;
	logic active;

	modport engine(input tick, input enable, input differential, input unlatched,
		input threshold, input duration, input mask, input sample,
		output event_pulse, output active);
	modport owner(output tick, output enable, output differential, output unlatched,
		output threshold, output duration, output mask, output sample,
		input event_pulse, input active);
endinterface : engine_if

`default_nettype wire

// >>> logic/rate_tick.sv
// programmable rate divider producing one-cycle enable pulses
`timescale 1ns/10ps
`default_nettype none

module rate_tick #(
	parameter int BASE_CYCLES = 8000000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// control
	input wire logic enable_i,
	input wire logic [2:0] code_i,
	// pulse
	output logic tick_o
);
	import wake_pkg::*;

	tick_state_t st_reg, st_next;
	logic [31:0] period;

	always_comb begin
		// each code step doubles the rate
		period = 32'(BASE_CYCLES) >> code_i;
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (!enable_i) begin
			st_next.count = 32'h0;
		end else if (st_reg.count + 32'h1 >= period) begin
			st_next.count = 32'h0;
			st_next.tick = 1'b1;
		end else begin
			st_next.count = st_reg.count + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_o = st_reg.tick;
endmodule : rate_tick

`default_nettype wire

// >>> logic/motion_engine.sv
// motion wake-up engine: threshold, direction mask and debounce count
`timescale 1ns/10ps
`default_nettype none

module motion_engine #(
	parameter int SHIFT = 10
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// core side
	engine_if.engine eng
);
	import wake_pkg::*;

	engine_state_t st_reg, st_next;
	logic hit;
	logic [7:0] need;

	function automatic logic exceeds(axes_t cur, axes_t prev, logic diff, logic [7:0] th,
		logic [5:0] mask);
		logic signed [16:0] v;
		logic signed [16:0] lim;
		logic any;
		any = 1'b0;
		lim = $signed({9'h000, th});
		for (int i = 0; i < 3; i++) begin
			v = $signed({cur[i][15], cur[i]});
			// change from the previous reading, not absolute field
			if (diff) begin
				v = v - $signed({prev[i][15], prev[i]});
			end
			v = v >>> SHIFT;
			if (mask[4 - 2 * i] && v > lim) begin
				any = 1'b1;
			end
			if (mask[5 - 2 * i] && v < -lim) begin
				any = 1'b1;
			end
		end
		return any;
	endfunction : exceeds

	always_comb begin
		hit = exceeds(eng.sample, st_reg.prev, eng.differential, eng.threshold, eng.mask);
		need = (eng.duration == 8'h00) ? 8'h01 : eng.duration;
		st_next = st_reg;
		st_next.event_out = 1'b0;
		if (!eng.enable) begin
			st_next.mode = ENG_IDLE;
			st_next.count = 8'h00;
			st_next.prev = eng.sample;
		end else if (eng.tick) begin
			st_next.prev = eng.sample;
			case (st_reg.mode)
				ENG_IDLE, ENG_COUNT: begin
					if (hit) begin
						// fire only after the programmed count of samples
						st_next.count = st_reg.count + 8'h01;
						if (st_reg.count + 8'h01 >= need) begin
							st_next.mode = ENG_FIRED;
							st_next.event_out = 1'b1;
						end else begin
							st_next.mode = ENG_COUNT;
						end
					end else begin
						st_next.mode = ENG_IDLE;
						st_next.count = 8'h00;
					end
				end
				ENG_FIRED: begin
					// one event per motion run; rearm when it stops
					if (!hit) begin
						st_next.mode = ENG_IDLE;
						st_next.count = 8'h00;
					end
				end
				default: begin
					st_next.mode = ENG_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign eng.event_pulse = st_reg.event_out;
	assign eng.active = (st_reg.mode == ENG_FIRED);
endmodule : motion_engine

`default_nettype wire

// >>> logic/motion_wakeup_interrupt_logic.sv
// sensing core: enables, rates, sample registers, wake-up engines and interrupt pin
`timescale 1ns/10ps
`default_nettype none
`include "wake_cfg.svh"

// ====================================================================
// top module
// Summary of operation
// - writing zero to enable control stops both sensors and all sampling
// - value 0x0F: temp off, 2g range, high resolution, both sensors running
// - rate value 0x22 gives 50 Hz for both sensors and is the reset value
// - each axis reads as low and high byte in two's complement
// - routing 0x18 sends accel and magnet new-data events to pin one
// - routing 0x02 sends accel motion events to pin one
// - routing 0x01 sends magnet motion events to pin one
// - pin config 0x04: push-pull, active high, latched
// - accel mask 0x3F arms all six directions
// - magnet mask 0x3F arms all six directions
// - accel threshold is 16 counts per g
// - accel control 0x86: engine on, latched, 50 Hz evaluation
// - accel wake fires after threshold exceeded for programmed sample count
// - accel motion detection only while accel is enabled
// - accel wake sets status bit 1 and drives the pin when routing bit 1 is set
// - magnet threshold compared against change from previous reading
// - magnet control 0x86: engine on, latched, 50 Hz evaluation
// - magnet wake fires after change persists for programmed sample count
// - magnet detection runs only while magnet is enabled
// - magnet wake sets status bit 0
// - reading release register deasserts the latched pin
// - pulse mode gives about 50 us pin pulse per event, self clearing
// - release read also clears status bits and pending flag
module motion_wakeup_interrupt_logic #(
	parameter int ODR_BASE_CYCLES = `US_TO_CYCLES(`ODR_SLOW_PERIOD_US),
	parameter int ENGINE_BASE_CYCLES = `US_TO_CYCLES(`ENG_SLOW_PERIOD_US),
	parameter int PULSE_CYCLES = `US_TO_CYCLES(`INT_PULSE_TIME_US),
	parameter int ACCEL_SHIFT = 10,
	parameter int MAGNET_SHIFT = 0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// register access
	input wire logic [7:0] addr_i,
	input wire logic wr_en_i,
	input wire logic [7:0] wr_data_i,
	input wire logic rd_en_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	// raw converter samples
	input wire wake_pkg::axes_t accel_raw_i,
	input wire wake_pkg::axes_t magnet_raw_i,
	// interrupt pin one
	output logic interrupt_pin_one_o,
	output logic interrupt_pin_one_oe_o,
	// sensor state
	output logic accel_run_o,
	output logic magnet_run_o,
	output logic temp_run_o
);
	import wake_pkg::*;

	// ====================================================================
	// declarations
	top_state_t st_reg, st_next;
	logic [3:0] tick;
	logic [3:0] tick_en;
	logic [3:0][2:0] tick_code;
	logic accel_en;
	logic magnet_en;
	logic [4:0] hw_set;
	logic [4:0] routed;
	logic release_rd;
	logic asserted;
	logic level;
	logic pin_enable;

	engine_if accel_eng ();
	engine_if magnet_eng ();

	function automatic logic [7:0] axis_byte(axes_t a, logic [7:0] off);
		logic [7:0] b;
		case (off)
			8'h00: b = a[0][7:0];
			8'h01: b = a[0][15:8];
			8'h02: b = a[1][7:0];
			8'h03: b = a[1][15:8];
			8'h04: b = a[2][7:0];
			8'h05: b = a[2][15:8];
			default: b = 8'h00;
		endcase
		return b;
	endfunction : axis_byte

	function automatic logic in_block(logic [7:0] addr, logic [7:0] base);
		return (addr >= base) && (addr < base + 8'h06);
	endfunction : in_block

	// ====================================================================
	// sensor enables and rate dividers
	assign accel_en = st_reg.enable[`EN_ACCEL];
	assign magnet_en = st_reg.enable[`EN_MAGNET];
	assign accel_run_o = accel_en;
	assign magnet_run_o = magnet_en;
	assign temp_run_o = st_reg.enable[6];

	// 0: accel output rate, 1: magnet output rate, 2/3: engine evaluation rates
	assign tick_en[0] = accel_en;
	assign tick_en[1] = magnet_en;
	assign tick_en[2] = accel_en && st_reg.actl[`ENG_ENABLE];
	assign tick_en[3] = magnet_en && st_reg.mctl[`ENG_ENABLE];
	assign tick_code[0] = st_reg.rate[2:0];
	assign tick_code[1] = st_reg.rate[6:4];
	assign tick_code[2] = st_reg.actl[2:0];
	assign tick_code[3] = st_reg.mctl[2:0];

	generate
		for (genvar i = 0; i < 4; i++) begin : g_rate
			rate_tick #(
				.BASE_CYCLES((i < 2) ? ODR_BASE_CYCLES : ENGINE_BASE_CYCLES)
			) u_rate (
				.clk_i(clk_i),
				.reset_i(reset_i),
				.enable_i(tick_en[i]),
				.code_i(tick_code[i]),
				.tick_o(tick[i])
			);
		end
	endgenerate

	// ====================================================================
	// motion engines
	assign accel_eng.tick = tick[2];
	assign accel_eng.enable = tick_en[2];
	assign accel_eng.differential = 1'b0;
	assign accel_eng.unlatched = st_reg.actl[`ENG_UNLATCHED];
	assign accel_eng.threshold = st_reg.ath;
	assign accel_eng.duration = st_reg.adur;
	assign accel_eng.mask = st_reg.amask[5:0];
	assign accel_eng.sample = st_reg.accel;

	assign magnet_eng.tick = tick[3];
	assign magnet_eng.enable = tick_en[3];
	// magnet engine works on the change between readings
	assign magnet_eng.differential = 1'b1;
	assign magnet_eng.unlatched = st_reg.mctl[`ENG_UNLATCHED];
	assign magnet_eng.threshold = st_reg.mth;
	assign magnet_eng.duration = st_reg.mdur;
	assign magnet_eng.mask = st_reg.mmask[5:0];
	assign magnet_eng.sample = st_reg.magnet;

	motion_engine #(
		.SHIFT(ACCEL_SHIFT)
	) u_accel_engine (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.eng(accel_eng.engine)
	);

	motion_engine #(
		.SHIFT(MAGNET_SHIFT)
	) u_magnet_engine (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.eng(magnet_eng.engine)
	);

	// ====================================================================
	// events and routing
	always_comb begin
		hw_set = 5'b00000;
		hw_set[`STAT_ACCEL_DRDY] = tick[0];
		hw_set[`STAT_MAGNET_DRDY] = tick[1];
		hw_set[`STAT_ACCEL_WAKE] = accel_eng.event_pulse;
		hw_set[`STAT_MAGNET_WAKE] = magnet_eng.event_pulse;
		// routing bits sit on the same positions as the status bits
		routed = hw_set & st_reg.routing[4:0];
	end

	assign release_rd = rd_en_i && (addr_i == `REG_RELEASE);

	// ====================================================================
	// next-state
	always_comb begin
		st_next = st_reg;
		st_next.rd_valid = 1'b0;

		// register writes; reconfiguring while sensors run is the host's hazard
		if (wr_en_i) begin
			case (addr_i)
				`REG_ROUTING: st_next.routing = wr_data_i;
				`REG_PIN_CFG: st_next.pin_cfg = wr_data_i;
				`REG_ACCEL_MASK: st_next.amask = wr_data_i;
				`REG_MAGNET_MASK: st_next.mmask = wr_data_i;
				`REG_ACCEL_THRESH: st_next.ath = wr_data_i;
				`REG_ACCEL_DUR: st_next.adur = wr_data_i;
				`REG_ACCEL_CTL: st_next.actl = wr_data_i;
				`REG_MAGNET_THRESH: st_next.mth = wr_data_i;
				`REG_MAGNET_DUR: st_next.mdur = wr_data_i;
				`REG_MAGNET_CTL: st_next.mctl = wr_data_i;
				`REG_RATE: st_next.rate = wr_data_i;
				`REG_ENABLE: st_next.enable = wr_data_i;
				default: begin
				end
			endcase
		end

		// sample capture only at the output rate of an enabled sensor
		if (tick[0]) begin
			st_next.accel = accel_raw_i;
		end
		if (tick[1]) begin
			st_next.magnet = magnet_raw_i;
		end

		// register reads
		if (rd_en_i) begin
			st_next.rd_valid = 1'b1;
			if (in_block(addr_i, `REG_ACCEL_BASE)) begin
				st_next.rd_data = axis_byte(st_reg.accel, addr_i - `REG_ACCEL_BASE);
			end else if (in_block(addr_i, `REG_MAGNET_BASE)) begin
				st_next.rd_data = axis_byte(st_reg.magnet, addr_i - `REG_MAGNET_BASE);
			end else begin
				case (addr_i)
					`REG_STATUS_ONE: st_next.rd_data = {3'b000, st_reg.status};
					`REG_RELEASE: st_next.rd_data = {3'b000, st_reg.status};
					`REG_STATUS_GEN: st_next.rd_data = {3'b000, st_reg.pending, 4'h0};
					`REG_ROUTING: st_next.rd_data = st_reg.routing;
					`REG_PIN_CFG: st_next.rd_data = st_reg.pin_cfg;
					`REG_ACCEL_MASK: st_next.rd_data = st_reg.amask;
					`REG_MAGNET_MASK: st_next.rd_data = st_reg.mmask;
					`REG_ACCEL_THRESH: st_next.rd_data = st_reg.ath;
					`REG_ACCEL_DUR: st_next.rd_data = st_reg.adur;
					`REG_ACCEL_CTL: st_next.rd_data = st_reg.actl;
					`REG_MAGNET_THRESH: st_next.rd_data = st_reg.mth;
					`REG_MAGNET_DUR: st_next.rd_data = st_reg.mdur;
					`REG_MAGNET_CTL: st_next.rd_data = st_reg.mctl;
					`REG_RATE: st_next.rd_data = st_reg.rate;
					`REG_ENABLE: st_next.rd_data = st_reg.enable;
					default: st_next.rd_data = 8'h00;
				endcase
			end
		end

		// release read clears status and pending but not the pulse count; a same-cycle event still lands
		if (release_rd) begin
			st_next.status = 5'b00000;
			st_next.pending = 1'b0;
		end
		// an unlatched engine's flag follows its motion state
		if (st_reg.actl[`ENG_UNLATCHED] && !accel_eng.active) begin
			st_next.status[`STAT_ACCEL_WAKE] = 1'b0;
		end
		if (st_reg.mctl[`ENG_UNLATCHED] && !magnet_eng.active) begin
			st_next.status[`STAT_MAGNET_WAKE] = 1'b0;
		end
		st_next.status = st_next.status | hw_set;
		if (routed != 5'b00000) begin
			st_next.pending = 1'b1;
		end

		// pulse mode: fixed-length pin pulse, restarted by each event
		if (routed != 5'b00000) begin
			st_next.pulse_cnt = 16'(PULSE_CYCLES);
		end else if (st_reg.pulse_cnt != 16'h0000) begin
			st_next.pulse_cnt = st_reg.pulse_cnt - 16'h0001;
		end
	end

	// ====================================================================
	// state register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg <= '0;
			st_reg.rate <= `RATE_RESET;
			st_reg.pin_cfg <= `CFG_RESET;
			st_reg.enable <= `CFG_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ====================================================================
	// interrupt pin
	always_comb begin
		pin_enable = !st_reg.pin_cfg[`PIN_DISABLE];
		// latched mode holds until release; pulse mode ignores the latch
		if (st_reg.pin_cfg[`PIN_PULSE]) begin
			asserted = (st_reg.pulse_cnt != 16'h0000);
		end else begin
			asserted = st_reg.pending;
		end
		level = st_reg.pin_cfg[`PIN_ACTIVE_HIGH] ? asserted : !asserted;
		if (!pin_enable) begin
			interrupt_pin_one_o = 1'b0;
			interrupt_pin_one_oe_o = 1'b0;
		end else if (st_reg.pin_cfg[`PIN_OPEN_DRAIN]) begin
			// open drain only ever pulls low
			interrupt_pin_one_o = 1'b0;
			interrupt_pin_one_oe_o = !level;
		end else begin
			interrupt_pin_one_o = level;
			interrupt_pin_one_oe_o = 1'b1;
		end
	end

	assign rd_data_o = st_reg.rd_data;
	assign rd_valid_o = st_reg.rd_valid;
endmodule : motion_wakeup_interrupt_logic

`default_nettype wire

// >>> testbench/wake_chk.sv
// port assertions for the wake-up core
`timescale 1ns/10ps
`default_nettype none
`include "wake_cfg.svh"

module wake_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// register access
	input wire logic [7:0] addr_i,
	input wire logic wr_en_i,
	input wire logic [7:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic [7:0] rd_data_o,
	input wire logic rd_valid_o,
	// samples
	input wire wake_pkg::axes_t accel_raw_i,
	input wire wake_pkg::axes_t magnet_raw_i,
	// pin and sensor state
	input wire logic interrupt_pin_one_o,
	input wire logic interrupt_pin_one_oe_o,
	input wire logic accel_run_o,
	input wire logic magnet_run_o,
	input wire logic temp_run_o
);
	import wake_pkg::*;
	logic [7:0] pin_cfg_reg;
	logic is_release;
	logic en_write;

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	assign is_release = rd_en_i && addr_i == `REG_RELEASE;
	assign en_write = wr_en_i && addr_i == `REG_ENABLE;

	// shadow of the pin setup so latch checks know the mode
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pin_cfg_reg <= `CFG_RESET;
		end else if (wr_en_i && addr_i == `REG_PIN_CFG) begin
			pin_cfg_reg <= wr_data_i;
		end
	end

	read_answer_a: assert property (rd_en_i |=> rd_valid_o)
		else $error("read not answered");
	read_quiet_a: assert property (!rd_en_i |=> !rd_valid_o)
		else $error("answer without read");
	sensors_off_a: assert property (en_write && wr_data_i == 8'h00
		|=> !accel_run_o && !magnet_run_o && !temp_run_o) else $error("sensors not stopped");
	sensors_on_a: assert property (en_write && wr_data_i == 8'h0F
		|=> accel_run_o && magnet_run_o && !temp_run_o) else $error("sensors not started");
	run_follow_a: assert property (en_write |=> accel_run_o == $past(wr_data_i[0])
		&& magnet_run_o == $past(wr_data_i[1]) && temp_run_o == $past(wr_data_i[6]))
		else $error("run bits differ from written value");
	run_hold_a: assert property (!en_write |=> $stable({accel_run_o, magnet_run_o, temp_run_o}))
		else $error("run bits moved without write");
	push_pull_a: assert property (pin_cfg_reg == 8'h04 |-> interrupt_pin_one_oe_o)
		else $error("pin not driven");
	latch_hold_a: assert property (pin_cfg_reg == 8'h04 && interrupt_pin_one_o
		&& !is_release && !wr_en_i |=> interrupt_pin_one_o) else $error("latched pin dropped");
	unmapped_zero_a: assert property (rd_en_i && addr_i == 8'h50 |=> rd_data_o == 8'h00)
		else $error("unmapped read not zero");
	read_back_a: assert property (rd_en_i && !wr_en_i && !$past(wr_en_i) && $past(wr_en_i, 2)
		&& $past(addr_i, 2) == addr_i && addr_i inside {[8'h2A:8'h34]}
		|=> rd_data_o == $past(wr_data_i, 3)) else $error("register read back differs");

	cover property (is_release ##1 !interrupt_pin_one_o);
	cover property ($rose(interrupt_pin_one_o) && pin_cfg_reg == 8'h04);
	cover property (en_write && wr_data_i == 8'h0F);
endmodule : wake_chk

`default_nettype wire

// >>> testbench/host_model.sv
// host side of the register port: one-cycle write and read strobes
`timescale 1ns/10ps
`default_nettype none

module host_model (
	// clock
	input wire logic clk_i,
	// register access
	output var logic [7:0] addr_o,
	output var logic wr_en_o,
	output var logic [7:0] wr_data_o,
	output var logic rd_en_o,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i
);
	initial begin
		addr_o = 8'h00;
		wr_en_o = 1'b0;
		wr_data_o = 8'h00;
		rd_en_o = 1'b0;
	end

	// called just after a falling edge; the strobe is taken at the next rising edge
	// a spare cycle follows so the next call never re-raises a strobe in the same step
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		addr_o = a;
		wr_data_o = d;
		wr_en_o = 1'b1;
		@(negedge clk_i);
		wr_en_o = 1'b0;
		@(negedge clk_i);
	endtask : write_reg

	// the answer stands for one cycle, so it is taken at the following falling edge
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
		addr_o = a;
		rd_en_o = 1'b1;
		@(negedge clk_i);
		rd_en_o = 1'b0;
		d = rd_data_i;
		v = rd_valid_i;
		@(negedge clk_i);
	endtask : read_reg
endmodule : host_model

`default_nettype wire

// >>> testbench/tb_motion_wakeup_interrupt_logic.sv
// self-checking bench for the wake-up core
`timescale 1ns/10ps
`default_nettype none
`include "wake_cfg.svh"

module tb_motion_wakeup_interrupt_logic;
	import wake_pkg::*;
	localparam int PULSE = 8;
	localparam int LIMIT = 10000;
	logic clk, reset, wr_en, rd_en, rd_valid, pin, pin_oe, ramp_on;
	logic accel_run, magnet_run, temp_run;
	logic [7:0] addr, wr_data, rd_data;
	axes_t accel_raw, magnet_raw;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;

	// ====================================================================
	// design and host
	motion_wakeup_interrupt_logic #(.ODR_BASE_CYCLES(400), .ENGINE_BASE_CYCLES(6400),
		.PULSE_CYCLES(PULSE)) uut (.clk_i(clk), .reset_i(reset), .addr_i(addr),
		.wr_en_i(wr_en), .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_data_o(rd_data),
		.rd_valid_o(rd_valid), .accel_raw_i(accel_raw), .magnet_raw_i(magnet_raw),
		.interrupt_pin_one_o(pin), .interrupt_pin_one_oe_o(pin_oe), .accel_run_o(accel_run),
		.magnet_run_o(magnet_run), .temp_run_o(temp_run));
	host_model host (.clk_i(clk), .addr_o(addr), .wr_en_o(wr_en), .wr_data_o(wr_data),
		.rd_en_o(rd_en), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

	always #5 clk = ~clk;

	// a field that keeps changing, so the differential engine sees motion
	always @(negedge clk) begin
		if (ramp_on) begin
			magnet_raw[0] <= magnet_raw[0] + 16'h0001;
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// ====================================================================
	// helpers
	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_byte

	task automatic chk_flag(input logic got, input logic exp, input string what);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s: got %b expected %b", $time, what, got, exp);
		end
	endtask : chk_flag

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic v;
		host.read_reg(a, d, v);
		chk_flag(v, 1'b1, "read answer");
	endtask : rd

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle

	task automatic wait_pin(input logic lvl, input int max, output int n);
		n = 0;
		while (pin !== lvl && n < max) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_pin

	task automatic setup(input logic [7:0] route, input logic [7:0] cfg);
		logic [7:0] d;
		host.write_reg(`REG_ENABLE, 8'h00);
		host.write_reg(`REG_ROUTING, route);
		host.write_reg(`REG_PIN_CFG, cfg);
		rd(`REG_RELEASE, d);
	endtask : setup

	// ====================================================================
	// scenarios
	task automatic t_reset();
		logic [7:0] d;
		chk_flag(pin, 1'b1, "idle level after reset");
		rd(`REG_RATE, d);
		chk_byte(d, 8'h22, "rate after reset");
		chk_flag(accel_run, 1'b0, "accel idle");
		host.write_reg(`REG_ACCEL_THRESH, 8'h08);
		rd(`REG_ACCEL_THRESH, d);
		chk_byte(d, 8'h08, "threshold read back");
		rd(8'h50, d);
		chk_byte(d, 8'h00, "unmapped read");
	endtask : t_reset

	task automatic t_sample();
		logic [7:0] d;
		int n;
		accel_raw = {16'h0000, 16'h0000, 16'h8123};
		magnet_raw = {16'h0000, 16'hFE7F, 16'h0000};
		setup(8'h18, 8'h04);
		host.write_reg(`REG_RATE, 8'h22);
		host.write_reg(`REG_ENABLE, 8'h0F);
		chk_flag(temp_run, 1'b0, "temperature off");
		wait_pin(1'b1, 300, n);
		chk_flag(pin, 1'b1, "new data on pin");
		rd(`REG_RELEASE, d);
		chk_flag(|(d & 8'h18), 1'b1, "data ready status");
		chk_flag(pin, 1'b0, "pin released");
		idle(100);
		rd(`REG_ACCEL_BASE, d);
		chk_byte(d, 8'h23, "accel x low");
		rd(`REG_ACCEL_BASE + 8'h01, d);
		chk_byte(d, 8'h81, "accel x high");
		rd(`REG_MAGNET_BASE + 8'h02, d);
		chk_byte(d, 8'h7F, "magnet y low");
		rd(`REG_MAGNET_BASE + 8'h03, d);
		chk_byte(d, 8'hFE, "magnet y high");
		setup(8'h18, 8'h04);
		accel_raw = '0;
		idle(300);
		chk_flag(pin, 1'b0, "no data while off");
		rd(`REG_ACCEL_BASE, d);
		chk_byte(d, 8'h23, "sample frozen");
	endtask : t_sample

	task automatic t_accel();
		logic [7:0] d;
		int n;
		setup(8'h02, 8'h04);
		host.write_reg(`REG_ACCEL_MASK, 8'h3F);
		host.write_reg(`REG_ACCEL_THRESH, 8'h08);
		host.write_reg(`REG_ACCEL_CTL, 8'h86);
		host.write_reg(`REG_ACCEL_DUR, 8'h05);
		accel_raw = {16'h0000, 16'h0000, 16'hD800};
		idle(700);
		chk_flag(pin, 1'b0, "accel disabled");
		host.write_reg(`REG_ENABLE, 8'h01);
		idle(350);
		chk_flag(pin, 1'b0, "before debounce");
		wait_pin(1'b1, 800, n);
		chk_flag(pin, 1'b1, "accel wake pin");
		rd(`REG_RELEASE, d);
		chk_byte(d & 8'h02, 8'h02, "accel wake status");
		chk_flag(pin, 1'b0, "pin released");
		rd(`REG_STATUS_ONE, d);
		chk_byte(d & 8'h02, 8'h00, "status cleared");
		rd(`REG_STATUS_GEN, d);
		chk_byte(d & 8'h10, 8'h00, "pending cleared");
		accel_raw = '0;
	endtask : t_accel

	task automatic t_magnet();
		logic [7:0] d;
		int n;
		magnet_raw = {3{16'h7000}};
		setup(8'h01, 8'h04);
		host.write_reg(`REG_MAGNET_MASK, 8'h3F);
		host.write_reg(`REG_MAGNET_THRESH, 8'h01);
		host.write_reg(`REG_MAGNET_CTL, 8'h86);
		host.write_reg(`REG_MAGNET_DUR, 8'h05);
		host.write_reg(`REG_RATE, 8'h32);
		host.write_reg(`REG_ENABLE, 8'h02);
		chk_flag(magnet_run, 1'b1, "magnet running");
		idle(800);
		chk_flag(pin, 1'b0, "steady field");
		ramp_on = 1'b1;
		wait_pin(1'b1, 1000, n);
		chk_flag(pin, 1'b1, "magnet wake pin");
		chk_flag(n > 300, 1'b1, "debounce time");
		rd(`REG_RELEASE, d);
		chk_byte(d & 8'h01, 8'h01, "magnet wake status");
		ramp_on = 1'b0;
	endtask : t_magnet

	task automatic t_pulse();
		int n;
		setup(8'h18, 8'h0C);
		host.write_reg(`REG_RATE, 8'h22);
		host.write_reg(`REG_ENABLE, 8'h01);
		wait_pin(1'b1, 300, n);
		wait_pin(1'b0, 50, n);
		chk_byte(8'(n), 8'(PULSE), "pulse length");
		host.write_reg(`REG_PIN_CFG, 8'h20);
		chk_flag(pin_oe, 1'b0, "pin disabled");
	endtask : t_pulse

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		ramp_on = 1'b0;
		accel_raw = '0;
		magnet_raw = '0;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		t_reset();
		t_sample();
		t_accel();
		t_magnet();
		t_pulse();
		tally_and_finish();
	end
endmodule : tb_motion_wakeup_interrupt_logic

bind motion_wakeup_interrupt_logic wake_chk chk (.clk_i(clk_i), .reset_i(reset_i),
	.addr_i(addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i),
	.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .accel_raw_i(accel_raw_i),
	.magnet_raw_i(magnet_raw_i), .interrupt_pin_one_o(interrupt_pin_one_o),
	.interrupt_pin_one_oe_o(interrupt_pin_one_oe_o), .accel_run_o(accel_run_o),
	.magnet_run_o(magnet_run_o), .temp_run_o(temp_run_o));

`default_nettype wire
